// File: include/usb_ep_pkg.sv
// Constants, register map and carrier types for the bulk endpoint block
package usb_ep_pkg;
  localparam logic [15:0] OFF_PAIRING = 16'h0000;
  localparam logic [15:0] OFF_IN_VALID = 16'h0004;
  localparam logic [15:0] OFF_OUT_VALID = 16'h0008;
  localparam logic [15:0] OFF_IN_IRQ = 16'h000C;
  localparam logic [15:0] OFF_OUT_IRQ = 16'h0010;
  localparam logic [15:0] OFF_IN_IEN = 16'h0014;
  localparam logic [15:0] OFF_OUT_IEN = 16'h0018;
  localparam logic [15:0] OFF_BUSY = 16'h001C;
  localparam logic [15:0] OFF_CONTROL = 16'h0020;
  // Byte count blocks: base + 4 * endpoint, endpoints 1..7
  localparam logic [10:0] BLK_IN_BC = 11'h002;
  localparam logic [10:0] BLK_OUT_BC = 11'h003;
  // Buffer window: base + 4 * (buffer * 64 + byte)
  localparam logic [3:0] BLK_BUFFER = 4'h1;
  localparam logic [3:0] BUF_COUNT = 4'hE;
  localparam logic [3:0] OUT_BUF_BASE = 4'h6;
  localparam int RAM_WORDS = 1024;
  localparam logic [6:0] MAX_PACKET = 7'h40;
  localparam logic [5:0] PAIRING_RST = 6'h00;
  localparam logic [7:0] VALID_RST = 8'h00;
  localparam logic [7:0] EP0_VALID = 8'h01;
  localparam logic [1:0] IN_LOAD_RST = 2'h0;
  localparam logic [1:0] OUT_FREE_RST = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_IN_SEND = 3'b001,
    ST_IN_WAIT = 3'b010,
    ST_OUT_RECV = 3'b011,
    ST_OUT_DROP = 3'b100
  } link_state_e;

  typedef struct packed {
    logic valid;
    logic dir_in;
    logic [3:0] ep;
  } token_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic done;
    logic good;
  } rx_s;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tx_s;
endpackage

// File: rtl/pin_filter.sv
// Three-stage synchroniser with agreement filter for the reset pins
`timescale 1ns/1ps
module pin_filter import usb_ep_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] pin,
  output logic [1:0] level
);
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  wire [1:0] next_level = (s2 & s3) | (level & (s2 | s3));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
      level <= 2'h0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule // pin_filter

// File: rtl/packet_ram.sv
// Endpoint buffer memory, one port for software and one for the link
`timescale 1ns/1ps
module packet_ram import usb_ep_pkg::*; (
  input wire logic sys_clk,
  input wire logic a_we,
  input wire logic [9:0] a_addr,
  input wire logic [7:0] a_wdata,
  output logic [7:0] a_rdata,
  input wire logic b_we,
  input wire logic [9:0] b_addr,
  input wire logic [7:0] b_wdata,
  output logic [7:0] b_rdata
);
  logic [7:0] mem [0:RAM_WORDS-1];

  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  // Link write wins a same-address collision
  always_ff @(posedge sys_clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we && !(b_we && b_addr == a_addr)) begin
      mem[a_addr] <= a_wdata;
    end
  end
endmodule // packet_ram

// File: rtl/usb_bulk_endpoint_arming.sv
// Bulk and interrupt endpoint arming, handshake and buffer pairing logic
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module usb_bulk_endpoint_arming import usb_ep_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_bus_reset,
  input wire logic cpu_reset,
  input wire token_s token,
  input wire rx_s rx,
  input wire logic tx_ready,
  input wire logic host_ack,
  input wire logic host_miss,
  output tx_s tx,
  output logic tx_start,
  output logic [6:0] tx_len,
  output logic resp_ack,
  output logic resp_nak,
  output logic irq,
  output logic [3:0] irq_vector
);
  logic [1:0] rst_level;
  logic [5:0] pairing;
  logic [7:1] in_valid, out_valid, in_irq, out_irq, in_ien, out_ien;
  logic autovector_enable;
  logic [1:0] in_load [1:7];
  logic [1:0] out_free [1:7];
  logic [7:1] in_wptr, in_tptr, out_wptr, out_rptr;
  logic [7:1] in_pair, out_pair, in_busy, out_busy, in_done, out_acc;
  logic [7:1] in_wr, out_wr, in_w1c, out_w1c;
  logic [6:0] in_cnt [1:7];
  logic [6:0] out_cnt [1:7];
  link_state_e state;
  logic [2:0] cur_ep, cur_slot;
  logic [6:0] idx;
  logic [7:0] ram_a_rdata, ram_b_rdata;
  logic [31:0] rdata_mux;
  logic [3:0] next_vector;

  pin_filter u_pin_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin({cpu_reset, usb_bus_reset}),
    .level(rst_level)
  );
  wire ep_reset = rst | rst_level[0] | rst_level[1];

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire [2:0] apb_ep = paddr[4:2];
  wire in_bc_hit = paddr[15:5] == BLK_IN_BC && apb_ep != 3'h0 && paddr[1:0] == 2'h0;
  wire out_bc_hit = paddr[15:5] == BLK_OUT_BC && apb_ep != 3'h0 && paddr[1:0] == 2'h0;
  wire [3:0] apb_buf = paddr[11:8];
  wire buf_hit = paddr[15:12] == BLK_BUFFER && apb_buf < BUF_COUNT && paddr[1:0] == 2'h0;
  // Paired even endpoint accesses land in the alternate buffer while in_wptr or out_rptr is set
  wire buf_out = apb_buf > OUT_BUF_BASE;
  wire [2:0] buf_ep = buf_out ? 3'(apb_buf - OUT_BUF_BASE) : 3'(apb_buf + 4'h1);
  wire buf_alt = buf_hit && (buf_out ? out_rptr[buf_ep] : in_wptr[buf_ep]);
  wire reg_hit = paddr == OFF_PAIRING || paddr == OFF_IN_VALID || paddr == OFF_OUT_VALID ||
    paddr == OFF_IN_IRQ || paddr == OFF_OUT_IRQ || paddr == OFF_IN_IEN ||
    paddr == OFF_OUT_IEN || paddr == OFF_BUSY || paddr == OFF_CONTROL;
  wire mapped = reg_hit | in_bc_hit | out_bc_hit | buf_hit;
  wire [2:0] in_wslot = in_wptr[apb_ep] ? apb_ep + 3'h1 : apb_ep;
  wire [2:0] out_rslot = out_rptr[apb_ep] ? apb_ep + 3'h1 : apb_ep;
  wire [6:0] bc_value = pwdata[6:0] > MAX_PACKET ? MAX_PACKET : pwdata[6:0];

  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (paddr == OFF_PAIRING) rdata_mux[5:0] = pairing;
    if (paddr == OFF_IN_VALID) rdata_mux[7:0] = {in_valid, 1'b0} | EP0_VALID;
    if (paddr == OFF_OUT_VALID) rdata_mux[7:0] = {out_valid, 1'b0} | EP0_VALID;
    if (paddr == OFF_IN_IRQ) rdata_mux[7:1] = in_irq;
    if (paddr == OFF_OUT_IRQ) rdata_mux[7:1] = out_irq;
    if (paddr == OFF_IN_IEN) rdata_mux[7:1] = in_ien;
    if (paddr == OFF_OUT_IEN) rdata_mux[7:1] = out_ien;
    if (paddr == OFF_BUSY) rdata_mux[15:0] = {out_busy, 1'b0, in_busy, 1'b0};
    if (paddr == OFF_CONTROL) rdata_mux[0] = autovector_enable;
    if (in_bc_hit) rdata_mux[6:0] = in_cnt[apb_ep];
    if (out_bc_hit) rdata_mux[6:0] = out_cnt[out_rslot];
    if (buf_hit) rdata_mux[7:0] = ram_a_rdata;
  end

  // One wait-free access phase; setup latches the answer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      prdata <= (apb_setup & ~pwrite & mapped) ? rdata_mux : 32'h0000_0000;
    end
  end

  // Valid bits only follow the power-on reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_valid <= VALID_RST[7:1];
      out_valid <= VALID_RST[7:1];
      pairing <= PAIRING_RST;
      in_ien <= 7'h00;
      out_ien <= 7'h00;
      autovector_enable <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == OFF_IN_VALID) in_valid <= pwdata[7:1];
      if (paddr == OFF_OUT_VALID) out_valid <= pwdata[7:1];
      if (paddr == OFF_PAIRING) pairing <= pwdata[5:0];
      if (paddr == OFF_IN_IEN) in_ien <= pwdata[7:1];
      if (paddr == OFF_OUT_IEN) out_ien <= pwdata[7:1];
      if (paddr == OFF_CONTROL) autovector_enable <= pwdata[0];
    end
  end

  // IN count goes to the slot firmware is filling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 1; i <= 7; i++) in_cnt[i] <= 7'h00;
    end else if (apb_wr && in_bc_hit && !in_busy[apb_ep]) begin
      in_cnt[in_wslot] <= bc_value;
    end
  end

  // Per-endpoint arming state, same for bulk and interrupt type
  genvar k;
  generate
    for (k = 1; k <= 7; k++) begin : g_ep
      if (k == 2 || k == 4 || k == 6) begin : g_even
        assign in_pair[k] = pairing[k / 2 - 1];
        assign out_pair[k] = pairing[k / 2 + 2];
      end else begin : g_odd
        assign in_pair[k] = 1'b0;
        assign out_pair[k] = 1'b0;
      end
      wire [1:0] cap_in = in_pair[k] ? 2'h2 : 2'h1;
      wire [1:0] cap_out = out_pair[k] ? 2'h2 : 2'h1;
      assign in_busy[k] = in_load[k] == cap_in;
      assign out_busy[k] = out_free[k] == cap_out;
      assign in_wr[k] = apb_wr & in_bc_hit & apb_ep == k & ~in_busy[k];
      assign out_wr[k] = apb_wr & out_bc_hit & apb_ep == k;
      assign in_w1c[k] = apb_wr & paddr == OFF_IN_IRQ & pwdata[k];
      assign out_w1c[k] = apb_wr & paddr == OFF_OUT_IRQ & pwdata[k];
      wire out_inc = out_wr[k] & ~out_busy[k];
      always_ff @(posedge sys_clk) begin
        if (ep_reset) begin
          in_load[k] <= IN_LOAD_RST;
          out_free[k] <= OUT_FREE_RST;
          in_wptr[k] <= 1'b0;
          in_tptr[k] <= 1'b0;
          out_wptr[k] <= 1'b0;
          out_rptr[k] <= 1'b0;
          in_irq[k] <= 1'b0;
          out_irq[k] <= 1'b0;
        end else begin
          in_load[k] <= in_load[k] + {1'b0, in_wr[k]} - {1'b0, in_done[k]};
          out_free[k] <= out_free[k] + {1'b0, out_inc} - {1'b0, out_acc[k]};
          in_wptr[k] <= in_wptr[k] ^ (in_wr[k] & in_pair[k]);
          in_tptr[k] <= in_tptr[k] ^ (in_done[k] & in_pair[k]);
          out_wptr[k] <= out_wptr[k] ^ (out_acc[k] & out_pair[k]);
          out_rptr[k] <= out_rptr[k] ^ (out_inc & out_pair[k]);
          in_irq[k] <= (in_irq[k] & ~in_w1c[k]) | in_done[k];
          out_irq[k] <= (out_irq[k] & ~out_w1c[k]) | out_acc[k];
        end
      end
    end
  endgenerate

  // Link side
  wire [2:0] tok_ep = token.ep[2:0];
  wire tok_ok = token.valid && token.ep[3] == 1'b0 && tok_ep != 3'h0;
  wire tok_in = tok_ok && token.dir_in && in_valid[tok_ep];
  wire tok_out = tok_ok && !token.dir_in && out_valid[tok_ep];
  wire [2:0] tok_in_slot = in_tptr[tok_ep] ? tok_ep + 3'h1 : tok_ep;
  wire [2:0] tok_out_slot = out_wptr[tok_ep] ? tok_ep + 3'h1 : tok_ep;
  wire tx_room = !tx.valid || tx_ready;
  wire send_byte = state == ST_IN_SEND && tx_room && idx < tx_len;
  wire rx_take = state == ST_OUT_RECV && rx.valid && idx < MAX_PACKET;
  wire [3:0] link_buf = state == ST_OUT_RECV ? {1'b0, cur_slot} + OUT_BUF_BASE :
    {1'b0, cur_slot} - 4'h1;
  wire ack_ev = state == ST_IN_WAIT && host_ack;
  wire acc_ev = state == ST_OUT_RECV && rx.done && rx.good;

  generate
    for (k = 1; k <= 7; k++) begin : g_event
      assign in_done[k] = ack_ev & cur_ep == k;
      assign out_acc[k] = acc_ev & cur_ep == k;
    end
  endgenerate

  packet_ram u_packet_ram (
    .sys_clk(sys_clk),
    .a_we(apb_wr & buf_hit),
    .a_addr({apb_buf + {3'h0, buf_alt}, paddr[7:2]}),
    .a_wdata(pwdata[7:0]),
    .a_rdata(ram_a_rdata),
    .b_we(rx_take),
    .b_addr({link_buf, idx[5:0]}),
    .b_wdata(rx.data),
    .b_rdata(ram_b_rdata)
  );

  always_ff @(posedge sys_clk) begin
    if (ep_reset) begin
      state <= ST_IDLE;
      cur_ep <= 3'h0;
      cur_slot <= 3'h1;
      idx <= 7'h00;
      tx_len <= 7'h00;
      tx <= '0;
      tx_start <= 1'b0;
      resp_ack <= 1'b0;
      resp_nak <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      resp_ack <= 1'b0;
      resp_nak <= 1'b0;
      case (state)
        ST_IDLE: begin
          tx <= '0;
          idx <= 7'h00;
          cur_ep <= tok_ep;
          if (tok_in && in_load[tok_ep] != 2'h0) begin
            cur_slot <= tok_in_slot;
            tx_len <= in_cnt[tok_in_slot];
            tx_start <= 1'b1;
            state <= ST_IN_SEND;
          end else if (tok_in) begin
            resp_nak <= 1'b1;
          end else if (tok_out && out_free[tok_ep] != 2'h0) begin
            cur_slot <= tok_out_slot;
            state <= ST_OUT_RECV;
          end else if (tok_out) begin
            state <= ST_OUT_DROP;
          end
        end
        ST_IN_SEND: begin
          if (send_byte) begin
            tx.valid <= 1'b1;
            tx.data <= ram_b_rdata;
            tx.last <= idx == tx_len - 7'h01;
            idx <= idx + 7'h01;
          end else if (tx_room) begin
            tx <= '0;
            state <= ST_IN_WAIT;
          end
        end
        ST_IN_WAIT: begin
          if (host_ack || host_miss) begin
            state <= ST_IDLE;
          end
        end
        ST_OUT_RECV: begin
          if (rx_take) idx <= idx + 7'h01;
          if (rx.done) begin
            resp_ack <= rx.good;
            state <= ST_IDLE;
          end
        end
        ST_OUT_DROP: begin
          if (rx.done) begin
            resp_nak <= rx.good;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 1; i <= 7; i++) out_cnt[i] <= 7'h00;
    end else if (acc_ev) begin
      out_cnt[cur_slot] <= idx;
    end
  end

  // Processor request, any IN before any OUT, lowest endpoint first within each direction
  wire [7:1] in_pend = in_irq & in_ien;
  wire [7:1] out_pend = out_irq & out_ien;
  always_comb begin
    next_vector = 4'h0;
    for (int i = 7; i >= 1; i--) if (out_pend[i]) next_vector = {1'b1, 3'(i)};
    for (int i = 7; i >= 1; i--) if (in_pend[i]) next_vector = {1'b0, 3'(i)};
    if (!autovector_enable) next_vector = 4'h0;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
      irq_vector <= 4'h0;
    end else begin
      irq <= |{in_pend, out_pend};
      irq_vector <= next_vector;
    end
  end

  property p_in_nak;
    @(posedge sys_clk) disable iff (ep_reset)
    state == ST_IDLE && tok_in && in_load[tok_ep] == 2'h0 |=> resp_nak && !tx_start;
  endproperty
  a_in_nak: assert property (p_in_nak) else $error("unarmed IN not NAKed");
  property p_arm;
    @(posedge sys_clk) disable iff (ep_reset)
    in_wr[1] && !in_done[1] && in_load[1] == 2'h0 |=> in_busy[1];
  endproperty
  a_arm: assert property (p_arm) else $error("IN count write did not arm");
  property p_in_done;
    @(posedge sys_clk) disable iff (ep_reset)
    ack_ev |=> in_irq[$past(cur_ep)] && state == ST_IDLE;
  endproperty
  a_in_done: assert property (p_in_done) else $error("ACK did not raise request");
  property p_in_miss;
    @(posedge sys_clk) disable iff (ep_reset)
    state == ST_IN_WAIT && host_miss && !host_ack |=> in_load[cur_ep] != 2'h0;
  endproperty
  a_in_miss: assert property (p_in_miss) else $error("missing ACK dropped arming");
  property p_ep_reset;
    @(posedge sys_clk) rst_level != 2'h0 |=> in_busy == 7'h00 && out_free[3] == 2'h1;
  endproperty
  a_ep_reset: assert property (p_ep_reset) else $error("reset arming wrong");
  property p_valid_keep;
    @(posedge sys_clk) disable iff (rst)
    rst_level != 2'h0 |=> $stable(in_valid) && $stable(out_valid);
  endproperty
  a_valid_keep: assert property (p_valid_keep) else $error("valid bits lost");
  property p_irq;
    @(posedge sys_clk) disable iff (rst)
    (|{in_pend, out_pend}) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("request not signalled");
  property p_out_drop;
    @(posedge sys_clk) disable iff (ep_reset)
    state == ST_OUT_DROP && rx.done && rx.good |=> resp_nak && !resp_ack;
  endproperty
  a_out_drop: assert property (p_out_drop) else $error("unarmed OUT not NAKed");
  property p_out_acc;
    @(posedge sys_clk) disable iff (ep_reset)
    acc_ev |=> resp_ack && out_irq[$past(cur_ep)];
  endproperty
  a_out_acc: assert property (p_out_acc) else $error("OUT accept not acked");
  property p_out_bad;
    @(posedge sys_clk) disable iff (ep_reset)
    state == ST_OUT_RECV && rx.done && !rx.good |=> !resp_ack && !resp_nak;
  endproperty
  a_out_bad: assert property (p_out_bad) else $error("faulty packet answered");
endmodule // usb_bulk_endpoint_arming

// File: tb/usb_host_model.sv
// Behavioural USB host issuing IN and OUT tokens to the endpoint block
`timescale 1ns/1ps
module usb_host_model import usb_ep_pkg::*; (
  input wire logic sys_clk,
  output token_s token,
  output rx_s rx,
  output logic tx_ready,
  output logic host_ack,
  output logic host_miss,
  input wire tx_s tx,
  input wire logic tx_start,
  input wire logic [6:0] tx_len,
  input wire logic resp_ack,
  input wire logic resp_nak
);
  initial begin
    token = '0;
    rx = '0;
    tx_ready = 1'b1;
    host_ack = 1'b0;
    host_miss = 1'b0;
  end
  task automatic send_token(input logic dir_in, input logic [3:0] ep);
    @(posedge sys_clk);
    token <= '{valid: 1'b1, dir_in: dir_in, ep: ep};
    @(posedge sys_clk);
    token.valid <= 1'b0;
  endtask
  // Handshake code: 0 none, 1 data or ACK, 2 NAK
  task automatic in_xfer(input logic [3:0] ep, input logic ack, input logic slow,
                         output int hs, output int len, output logic [7:0] got[$]);
    hs = 0;
    len = -1;
    got = {};
    send_token(1'b1, ep);
    for (int k = 0; k < 4 && hs == 0; k++) begin
      @(posedge sys_clk);
      if (tx_start) begin
        hs = 1;
        len = tx_len;
      end else if (resp_nak) begin
        hs = 2;
      end
    end
    if (hs == 1) begin
      for (int k = 0; k < 300 && len > 0; k++) begin
        @(posedge sys_clk);
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx.valid && tx_ready) begin
          got.push_back(tx.data);
          if (tx.last) break;
        end
      end
      @(posedge sys_clk);
      tx_ready <= 1'b1;
      host_ack <= ack;
      host_miss <= !ack;
      @(posedge sys_clk);
      host_ack <= 1'b0;
      host_miss <= 1'b0;
    end
  endtask
  task automatic out_xfer(input logic [3:0] ep, input logic [7:0] data[$],
                          input logic good, output int hs);
    logic [7:0] last_b;
    hs = 0;
    last_b = 8'h00;
    send_token(1'b0, ep);
    foreach (data[i]) begin
      rx <= '{valid: 1'b1, data: data[i], done: 1'b0, good: 1'b0};
      last_b = data[i];
      @(posedge sys_clk);
    end
    // Released data lines show the inverse of the last byte
    rx <= '{valid: 1'b0, data: ~last_b, done: 1'b1, good: good};
    @(posedge sys_clk);
    rx <= '{valid: 1'b0, data: ~last_b, done: 1'b0, good: 1'b0};
    for (int k = 0; k < 4 && hs == 0; k++) begin
      @(posedge sys_clk);
      if (resp_ack) hs = 1;
      else if (resp_nak) hs = 2;
    end
  endtask
endmodule // usb_host_model

// File: tb/testbench.sv
// Self-checking bench for the bulk endpoint arming block
`timescale 1ns/1ps
module testbench import usb_ep_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, tx_ready, host_ack, host_miss;
  logic usb_bus_reset = 1'b0, cpu_reset = 1'b0;
  logic tx_start, resp_ack, resp_nak, irq;
  logic [6:0] tx_len;
  logic [3:0] irq_vector;
  token_s token;
  rx_s rx;
  tx_s tx;
  int error_cnt = 0, n_checks = 0, hs, len, m_busy;
  logic [31:0] seed = 32'hf758_505e;
  logic [7:0] got[$], pkt[$], pkt2[$], m_obuf[$];
  always #2.5 sys_clk = ~sys_clk;
  usb_bulk_endpoint_arming dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_bus_reset(usb_bus_reset),
    .cpu_reset(cpu_reset), .token(token), .rx(rx), .tx_ready(tx_ready),
    .host_ack(host_ack), .host_miss(host_miss), .tx(tx), .tx_start(tx_start),
    .tx_len(tx_len), .resp_ack(resp_ack), .resp_nak(resp_nak), .irq(irq),
    .irq_vector(irq_vector));
  usb_host_model host (.sys_clk(sys_clk), .token(token), .rx(rx), .tx_ready(tx_ready),
    .host_ack(host_ack), .host_miss(host_miss), .tx(tx), .tx_start(tx_start),
    .tx_len(tx_len), .resp_ack(resp_ack), .resp_nak(resp_nak));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    m_busy = 32'h0000_fe00;
    rchk("busy after reset", OFF_BUSY, m_busy);
    apb(1'b1, OFF_PAIRING, 32'h0000_002a);
    rchk("pairing", OFF_PAIRING, 32'h0000_002a);
    apb(1'b1, OFF_PAIRING, 32'h0);
    apb(1'b1, 16'h1e00, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, OFF_IN_VALID, 32'h2);
    apb(1'b1, OFF_OUT_VALID, 32'h2);
    host.in_xfer(4'h1, 1'b1, 1'b0, hs, len, got);
    chk("in nak unarmed", 32'd2, hs);
    $display("test reset done");
    pkt = {};
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      pkt.push_back(seed[7:0]);
      pkt2.push_back(~seed[7:0]);
      apb(1'b1, 16'h1000 + 16'(4 * i), {24'h0, seed[7:0]});
    end
    apb(1'b1, 16'h0044, 32'd5);
    m_busy |= 2;
    rchk("in busy set", OFF_BUSY, m_busy);
    for (int n = 0; n < 2; n++) begin
      host.in_xfer(4'h1, n[0], 1'b1, hs, len, got);
      chk("in len", 32'd5, len);
      chk("in payload", 32'h1, {31'h0, got == pkt});
      if (n == 1) m_busy &= ~2;
      rchk("in request", OFF_IN_IRQ, 32'(2 * n));
      rchk("in busy", OFF_BUSY, m_busy);
    end
    apb(1'b1, OFF_IN_IEN, 32'h2);
    apb(1'b1, OFF_CONTROL, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk("irq line", 32'h1, {31'h0, irq});
    chk("irq vector", 32'h1, {28'h0, irq_vector});
    apb(1'b1, OFF_IN_IRQ, 32'h0);
    rchk("request write zero", OFF_IN_IRQ, 32'h2);
    apb(1'b1, OFF_IN_IRQ, 32'h2);
    rchk("request cleared", OFF_IN_IRQ, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("irq released", 32'h0, {31'h0, irq});
    apb(1'b1, 16'h0044, 32'h0);
    host.in_xfer(4'h1, 1'b1, 1'b0, hs, len, got);
    chk("zero length", 32'h0, len + got.size());
    $display("test in done");
    apb(1'b1, OFF_PAIRING, 32'h0000_0001);
    apb(1'b1, OFF_IN_VALID, 32'h0000_0006);
    seed = lfsr(seed);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 16'h1100, {24'h0, seed[8 * i +: 8]});
      apb(1'b1, 16'h0048, 32'h0000_0001);
      rchk("pair busy load", OFF_BUSY, m_busy | 32'(4 * i));
    end
    for (int i = 0; i < 2; i++) begin
      host.in_xfer(4'h2, 1'b1, 1'b0, hs, len, got);
      chk("pair len", 32'h1, len);
      chk("pair payload", {24'h0, seed[8 * i +: 8]}, {24'h0, got[0]});
    end
    rchk("pair busy sent", OFF_BUSY, m_busy);
    rchk("pair request", OFF_IN_IRQ, 32'h0000_0006);
    apb(1'b1, OFF_PAIRING, 32'h0);
    apb(1'b1, OFF_IN_VALID, 32'h0000_0002);
    $display("test pair done");
    pkt = pkt[0:2];
    host.out_xfer(4'h1, pkt, 1'b0, hs);
    chk("bad packet silent", 32'h0, hs);
    rchk("busy after bad", OFF_BUSY, m_busy);
    host.out_xfer(4'h1, pkt, 1'b1, hs);
    chk("out ack", 32'h1, hs);
    m_obuf = pkt;
    m_busy &= ~32'h200;
    rchk("out busy cleared", OFF_BUSY, m_busy);
    rchk("out request", OFF_OUT_IRQ, 32'h2);
    rchk("out count", 16'h0064, 32'd3);
    host.out_xfer(4'h1, pkt2, 1'b1, hs);
    chk("out nak busy", 32'h2, hs);
    foreach (m_obuf[i]) rchk("out buffer", 16'h1700 + 16'(4 * i), {24'h0, m_obuf[i]});
    apb(1'b1, 16'h0064, 32'h0000_0055);
    m_busy |= 32'h200;
    rchk("out rearmed", OFF_BUSY, m_busy);
    $display("test out done");
    for (int r = 0; r < 2; r++) begin
      host.out_xfer(4'h1, pkt, 1'b1, hs);
      apb(1'b1, 16'h0044, 32'd4);
      if (r == 0) cpu_reset <= 1'b1;
      else usb_bus_reset <= 1'b1;
      repeat (10) @(posedge sys_clk);
      cpu_reset <= 1'b0;
      usb_bus_reset <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rchk("busy after pin reset", OFF_BUSY, 32'h0000_fe00);
      rchk("valid kept", OFF_IN_VALID, 32'h3);
      host.in_xfer(4'h1, 1'b1, 1'b0, hs, len, got);
      chk("nak after pin reset", 32'd2, hs);
    end
    $display("test pin reset done");
    summarize();
  end
endmodule // testbench
